// ===== sgm_pkg.sv
// constants, register map and types for the safety gate monitor
`default_nettype none
package sgm_pkg;
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned STEP_MS     = 10;
  localparam int unsigned STEP_CYC    = CLK_HZ / 1000 * STEP_MS;
  localparam int unsigned TIME_W      = 12;
  localparam logic [11:0] TIME_MAX    = 12'hbb8;  // 30 s in 10 ms steps
  localparam logic [11:0] DISC_RST    = 12'h003;  // 30 ms
  localparam logic [11:0] SYNC_RST    = 12'h01e;  // 300 ms

  localparam logic [11:0] CTRL_OFS    = 12'h000;
  localparam logic [11:0] DISC1_OFS   = 12'h004;
  localparam logic [11:0] DISC2_OFS   = 12'h008;
  localparam logic [11:0] SYNC_OFS    = 12'h00c;
  localparam logic [11:0] STAT_OFS    = 12'h010;

  // control word fields
  localparam int unsigned CTL_MODE_LSB = 0;
  localparam int unsigned CTL_MODE_MSB = 2;
  localparam int unsigned CTL_FTE      = 3;
  localparam int unsigned CTL_RUN      = 4;
  localparam int unsigned CTL_EN_D1    = 5;
  localparam int unsigned CTL_EN_D2    = 6;
  localparam int unsigned CTL_EN_TN    = 7;
  localparam int unsigned CTL_EN_SY    = 8;
  localparam int unsigned CTL_EN_TE    = 9;
  localparam int unsigned CTL_EN_FP    = 10;
  localparam int unsigned CTL_W        = 11;

  typedef enum logic [2:0] {
    SGM_SINGLE = 3'h0,
    SGM_EQ1    = 3'h1,
    SGM_COMP1  = 3'h2,
    SGM_EQ2    = 3'h3,
    SGM_COMP2  = 3'h4
  } sgm_mode_t;

  typedef enum logic [3:0] {
    GT_IDLE  = 4'b0001,
    GT_ACT   = 4'b0010,
    GT_OPEN  = 4'b0100,
    GT_CLOSE = 4'b1000
  } sgm_gt_t;
endpackage
`default_nettype wire

// ===== sgm_timer.sv
// step-counting timeout used for discrepancy and synchronisation checks
`timescale 1ns/1ps
`default_nettype none
module sgm_timer #(
  parameter int W = 12
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic         en_i,
  input  wire logic         tick_i,
  input  wire logic         run_i,
  input  wire logic [W-1:0] limit_i,
  output logic              expired_o
);
  logic [W-1:0] cnt_q;
  logic         exp_q;
  wire          at_max = &cnt_q;

  // refused at elaboration: a one-bit counter cannot saturate below its limit
  if (W < 2) begin : g_bad_width
    $error("sgm_timer: width too small");
  end

  // a zero limit never expires, which switches the check off
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else if (en_i) begin
      if (!run_i) begin
        cnt_q <= '0;
        exp_q <= 1'b0;
      end else begin
        if (tick_i && !at_max) cnt_q <= cnt_q + W'(1);
        exp_q <= (limit_i != '0) && (cnt_q >= limit_i);
      end
    end
  end

  assign expired_o = exp_q;
endmodule // sgm_timer
`default_nettype wire

// ===== sgm_top.sv
// safety gate monitor with apb register access
`timescale 1ns/1ps
`default_nettype none
module sgm_top #(
  parameter int unsigned STEP_CYCLES = sgm_pkg::STEP_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        clk_en_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [3:0]  sw_i,
  input  wire logic        test_req_i,
  output logic             permit_o,
  output logic             fault_o,
  output logic             disc1_err_o,
  output logic             disc2_err_o,
  output logic             sync_err_o,
  output logic             test_err_o,
  output logic             test_needed_o
);
  import sgm_pkg::*;

  localparam int TW = $clog2(STEP_CYCLES + 1);

  // refused at elaboration: the prescaler needs at least one cycle per step
  if (STEP_CYCLES < 1) begin : g_bad_step
    $error("sgm_top: STEP_CYCLES must be at least one");
  end

  function automatic logic pair_on(input logic nc, input logic b, input logic comp);
    pair_on = comp ? (nc & ~b) : (nc & b);
  endfunction

  function automatic logic pair_off(input logic nc, input logic b, input logic comp);
    pair_off = comp ? (~nc & b) : (~nc & ~b);
  endfunction

  function automatic logic pair_disagree(input logic nc, input logic b, input logic comp);
    pair_disagree = comp ? ~(nc ^ b) : (nc ^ b);
  endfunction

  // ---------------- pin synchronisers
  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic       treq_prev_q;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q      <= '0;
      sync_q      <= '0;
      treq_prev_q <= 1'b0;
    end else if (clk_en_i) begin
      meta_q      <= {test_req_i, sw_i};
      sync_q      <= meta_q;
      treq_prev_q <= sync_q[4];
    end
  end

  wire [3:0] s         = sync_q[3:0];
  wire       treq_rise = sync_q[4] & ~treq_prev_q;

  // ---------------- registers
  logic [CTL_W-1:0]  ctrl_q;
  logic [TIME_W-1:0] disc1_q;
  logic [TIME_W-1:0] disc2_q;
  logic [TIME_W-1:0] sync_t_q;
  logic [31:0]       rdata_q;
  logic              ready_q;
  logic              slverr_q;

  wire setup    = psel_i & ~penable_i & ~ready_q;
  wire wr_take  = psel_i & penable_i & ready_q & pwrite_i & ~slverr_q;
  wire hit_ctrl = (paddr_i == CTRL_OFS);
  wire hit_d1   = (paddr_i == DISC1_OFS);
  wire hit_d2   = (paddr_i == DISC2_OFS);
  wire hit_sy   = (paddr_i == SYNC_OFS);
  wire hit_st   = (paddr_i == STAT_OFS);
  wire [2:0]  wmode    = pwdata_i[CTL_MODE_MSB:CTL_MODE_LSB];
  wire        wmode_ok = (wmode <= SGM_COMP2);
  wire        wtime_ok = (pwdata_i[31:TIME_W] == '0) && (pwdata_i[TIME_W-1:0] <= TIME_MAX);
  wire        hit_time = hit_d1 | hit_d2 | hit_sy;
  wire        any_hit  = hit_ctrl | hit_time | hit_st;
  // status is read-only; bad mode or out-of-range time is refused, not clipped
  wire        bad_acc  = ~any_hit | (pwrite_i & hit_st) |
                         (pwrite_i & hit_ctrl & ~wmode_ok) |
                         (pwrite_i & hit_time & ~wtime_ok);

  logic [31:0] stat_w;
  logic [31:0] rd_mux;

  always_comb begin
    if (hit_ctrl)    rd_mux = {{(32-CTL_W){1'b0}}, ctrl_q};
    else if (hit_d1) rd_mux = {{(32-TIME_W){1'b0}}, disc1_q};
    else if (hit_d2) rd_mux = {{(32-TIME_W){1'b0}}, disc2_q};
    else if (hit_sy) rd_mux = {{(32-TIME_W){1'b0}}, sync_t_q};
    else if (hit_st) rd_mux = stat_w;
    else             rd_mux = 32'h0000_0000;
  end

  // one wait-free access cycle: ready is raised from the setup cycle
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_q  <= 1'b0;
      slverr_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
    end else if (clk_en_i) begin
      ready_q  <= setup;
      slverr_q <= setup & bad_acc;
      if (setup) rdata_q <= (pwrite_i | bad_acc) ? 32'h0000_0000 : rd_mux;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q   <= {{(CTL_W-3){1'b0}}, SGM_EQ1};
      disc1_q  <= DISC_RST;
      disc2_q  <= DISC_RST;
      sync_t_q <= SYNC_RST;
    end else if (clk_en_i && wr_take) begin
      if (hit_ctrl)    ctrl_q   <= pwdata_i[CTL_W-1:0];
      else if (hit_d1) disc1_q  <= pwdata_i[TIME_W-1:0];
      else if (hit_d2) disc2_q  <= pwdata_i[TIME_W-1:0];
      else if (hit_sy) sync_t_q <= pwdata_i[TIME_W-1:0];
    end
  end

  // ---------------- mode decode
  wire [2:0] mode  = ctrl_q[CTL_MODE_MSB:CTL_MODE_LSB];
  wire       fte   = ctrl_q[CTL_FTE];
  wire       run   = ctrl_q[CTL_RUN];
  wire       m_sgl = (mode == SGM_SINGLE);
  wire       comp  = (mode == SGM_COMP1) | (mode == SGM_COMP2);
  wire       two   = (mode == SGM_EQ2) | (mode == SGM_COMP2);

  // single channel watches input 1 only
  wire p1_on  = m_sgl ? s[0] : pair_on(s[0], s[1], comp);
  wire p1_off = m_sgl ? ~s[0] : pair_off(s[0], s[1], comp);
  wire p2_on  = pair_on(s[2], s[3], comp);
  wire p2_off = pair_off(s[2], s[3], comp);
  wire in_on  = two ? (p1_on & p2_on) : p1_on;
  wire in_off = two ? (p1_off & p2_off) : p1_off;

  wire d1_run = ~m_sgl & pair_disagree(s[0], s[1], comp);
  wire d2_run = two & pair_disagree(s[2], s[3], comp);
  wire sy_run = two & (p1_on ^ p2_on);

  // ---------------- step tick and timers
  logic [TW-1:0] pre_q;
  logic          tick_q;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_q  <= '0;
      tick_q <= 1'b0;
    end else if (clk_en_i) begin
      tick_q <= (pre_q == TW'(STEP_CYCLES - 1));
      pre_q  <= (pre_q == TW'(STEP_CYCLES - 1)) ? '0 : pre_q + TW'(1);
    end
  end

  logic d1_exp;
  logic d2_exp;
  logic sy_exp;

  sgm_timer #(.W(TIME_W)) u_disc1 (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .en_i      (clk_en_i),
    .tick_i    (tick_q),
    .run_i     (d1_run),
    .limit_i   (disc1_q),
    .expired_o (d1_exp)
  );

  sgm_timer #(.W(TIME_W)) u_disc2 (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .en_i      (clk_en_i),
    .tick_i    (tick_q),
    .run_i     (d2_run),
    .limit_i   (disc2_q),
    .expired_o (d2_exp)
  );

  sgm_timer #(.W(TIME_W)) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .en_i      (clk_en_i),
    .tick_i    (tick_q),
    .run_i     (sy_run),
    .limit_i   (sync_t_q),
    .expired_o (sy_exp)
  );

  // ---------------- errors, gate test and permit
  logic    run_prev_q;
  logic    d1_err_q;
  logic    d2_err_q;
  logic    sy_err_q;
  logic    te_err_q;
  logic    rearm_q;
  logic    block_q;
  logic    req_pend_q;
  sgm_gt_t gt_q;
  sgm_gt_t gt_d;

  wire restart  = run & ~run_prev_q;
  wire te_set   = fte & treq_rise & req_pend_q;
  wire any_err  = d1_err_q | d2_err_q | sy_err_q | te_err_q;
  wire err_new  = (d1_exp & ~d1_err_q) | (d2_exp & ~d2_err_q) |
                  (sy_exp & ~sy_err_q) | (te_set & ~te_err_q);
  wire gt_done  = (gt_q == GT_CLOSE) & in_on;
  wire gt_start = fte & (restart | err_new | treq_rise);
  // clearing path: re-cycle or restart without test; completed gate test, or re-cycle while no gate test runs, with it
  wire clr_ok   = fte ? (gt_done | ((gt_q == GT_IDLE) & rearm_q & in_on))
                      : ((rearm_q & in_on) | restart);

  always_comb begin
    gt_d = gt_q;
    case (gt_q)
      GT_IDLE:  gt_d = GT_IDLE;
      GT_ACT:   if (in_on) gt_d = GT_OPEN;
      GT_OPEN:  if (in_off) gt_d = GT_CLOSE;
      GT_CLOSE: if (in_on) gt_d = GT_IDLE;
      default:  gt_d = GT_IDLE;
    endcase
    if (!fte) gt_d = GT_IDLE;
    else if (gt_start) gt_d = GT_ACT;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gt_q       <= GT_IDLE;
      run_prev_q <= 1'b0;
      block_q    <= 1'b0;
      req_pend_q <= 1'b0;
      rearm_q    <= 1'b0;
    end else if (clk_en_i) begin
      gt_q       <= gt_d;
      run_prev_q <= run;
      // request-driven tests keep the permit; startup and error tests hold it off
      block_q    <= fte & ((restart | err_new) | (block_q & ~gt_done));
      req_pend_q <= fte & (treq_rise | (req_pend_q & ~gt_done));
      rearm_q    <= (any_err | err_new) & (in_off | (rearm_q & ~clr_ok));
    end
  end

  // set wins over clear on every error flag
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      d1_err_q <= 1'b0;
      d2_err_q <= 1'b0;
      sy_err_q <= 1'b0;
      te_err_q <= 1'b0;
    end else if (clk_en_i) begin
      d1_err_q <= d1_exp | (d1_err_q & ~(clr_ok & ~d1_run));
      d2_err_q <= d2_exp | (d2_err_q & ~(clr_ok & ~d2_run));
      sy_err_q <= sy_exp | (sy_err_q & ~(clr_ok & ~sy_run));
      te_err_q <= te_set | (te_err_q & ~clr_ok);
    end
  end

  logic permit_q;
  logic fault_q;
  logic d1_o_q;
  logic d2_o_q;
  logic sy_o_q;
  logic te_o_q;
  logic tn_o_q;

  wire permit_d = run & in_on & ~any_err & ~err_new & ~block_q;
  wire tneed_d  = fte & (gt_q != GT_IDLE);

  assign stat_w = {21'h000000, s, tneed_d, te_err_q, sy_err_q, d2_err_q, d1_err_q,
                   any_err, permit_q};

  // ---------------- registered outputs, each optional one gated by its enable

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      permit_q <= 1'b0;
      fault_q  <= 1'b0;
      d1_o_q   <= 1'b0;
      d2_o_q   <= 1'b0;
      sy_o_q   <= 1'b0;
      te_o_q   <= 1'b0;
      tn_o_q   <= 1'b0;
    end else if (clk_en_i) begin
      permit_q <= permit_d;
      fault_q  <= ctrl_q[CTL_EN_FP] & any_err;
      d1_o_q   <= ctrl_q[CTL_EN_D1] & d1_err_q;
      d2_o_q   <= ctrl_q[CTL_EN_D2] & d2_err_q;
      sy_o_q   <= ctrl_q[CTL_EN_SY] & sy_err_q;
      te_o_q   <= ctrl_q[CTL_EN_TE] & te_err_q;
      tn_o_q   <= ctrl_q[CTL_EN_TN] & tneed_d;
    end
  end

  assign permit_o      = permit_q;
  assign fault_o       = fault_q;
  assign disc1_err_o   = d1_o_q;
  assign disc2_err_o   = d2_o_q;
  assign sync_err_o    = sy_o_q;
  assign test_err_o    = te_o_q;
  assign test_needed_o = tn_o_q;
  assign prdata_o      = rdata_q;
  assign pready_o      = ready_q;
  assign pslverr_o     = slverr_q;
endmodule // sgm_top
`default_nettype wire

// ===== sgm_top_monitor.sv
// assertion checker bound to the safety gate monitor top
`timescale 1ns/1ps
`default_nettype none
module sgm_top_monitor (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [31:0] prdata_o,
  input wire logic [3:0]  sw_i,
  input wire logic        permit_o,
  input wire logic        fault_o,
  input wire logic        disc1_err_o,
  input wire logic        disc2_err_o,
  input wire logic        sync_err_o,
  input wire logic        test_err_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire any_err = disc1_err_o | disc2_err_o | sync_err_o | test_err_o;

  a_err_blocks_permit: assert property (any_err |-> !permit_o)
    else $error("permit high while an error output is set");
  a_fault_no_permit: assert property (fault_o |-> !permit_o)
    else $error("permit high while fault is set");
  // five samples covers the two sync flops plus the output register
  a_open_drops_permit: assert property ((!sw_i[0])[*5] |-> !permit_o)
    else $error("permit high with input one open");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  a_setup_answered: assert property (psel_i && !penable_i |=> pready_o)
    else $error("setup not answered on the next cycle");
  a_refusal_zero_data: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
    else $error("error response without ready or with data");
  a_reset_quiet: assert property ($past(rst_i) |-> !permit_o && !fault_o && !pready_o)
    else $error("output active just after reset");
  // the pin value that produced a rise is three samples old: two sync flops, one output flop
  a_rise_needs_input: assert property ($rose(permit_o) |-> $past(sw_i[0], 3))
    else $error("permit rose with input one open");

  c_permit: cover property ($rose(permit_o));
  c_disc: cover property ($rose(disc1_err_o) || $rose(disc2_err_o));
  c_refused: cover property (pslverr_o);
endmodule // sgm_top_monitor

bind sgm_top sgm_top_monitor u_mon (
  .ref_clk_i, .rst_i, .psel_i, .penable_i, .pready_o, .pslverr_o, .prdata_o, .sw_i,
  .permit_o, .fault_o, .disc1_err_o, .disc2_err_o, .sync_err_o, .test_err_o
);
`default_nettype wire

// ===== sgm_switch_model.sv
// switch contact model: each contact follows its target after a short random lag
`timescale 1ns/1ps
`default_nettype none
module sgm_switch_model (
  input  wire logic       ref_clk_i,
  input  wire logic [3:0] want_i,
  output var  logic [3:0] sw_o
);
  // real contacts never switch together, so each bit lags 0..2 cycles
  logic [1:0] lag_q [4];
  initial begin
    sw_o = 4'h0;
    for (int i = 0; i < 4; i++) begin
      lag_q[i] = 2'h0;
    end
  end
  always @(posedge ref_clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (sw_o[i] != want_i[i] && lag_q[i] == 2'h0) begin
        sw_o[i] <= want_i[i];
        lag_q[i] <= 2'($urandom_range(2));
      end else if (sw_o[i] != want_i[i]) begin
        lag_q[i] <= lag_q[i] - 2'h1;
      end
    end
  end
endmodule // sgm_switch_model
`default_nettype wire

// ===== sgm_top_bench.sv
// self-checking bench for the safety gate monitor
`timescale 1ns/1ps
`default_nettype none
module sgm_top_bench;
  import sgm_pkg::*;
  localparam int unsigned SC  = 4;
  localparam logic [31:0] ENS = 32'h7e0;
  localparam logic [31:0] RUN = 32'h10;
  localparam logic [31:0] FTE = 32'h8;
  logic        ref_clk_i, rst_i, psel, pen, pwr, req, rdy, serr;
  logic        permit, fault, d1, d2, sy, te, tn, en;
  logic [11:0] addr;
  logic [31:0] wdat, rdat;
  logic [3:0]  want, sw;
  logic [33:0] e;
  logic [33:0] q [$];
  int          miscompares, n_checks;

  sgm_top #(.STEP_CYCLES(SC)) DUT (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(en), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdat),
    .prdata_o(rdat), .pready_o(rdy), .pslverr_o(serr), .sw_i(sw), .test_req_i(req),
    .permit_o(permit), .fault_o(fault), .disc1_err_o(d1), .disc2_err_o(d2),
    .sync_err_o(sy), .test_err_o(te), .test_needed_o(tn)
  );
  sgm_switch_model u_sw (.ref_clk_i(ref_clk_i), .want_i(want), .sw_o(sw));

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp_bus(input logic [31:0] d, input logic r, input logic [33:0] x);
    n_checks++;
    if (r !== x[0] || (x[33] && d !== x[32:1])) begin
      miscompares++;
      $display("unexpected at %0t: bus %h/%b wanted %h/%b", $time, d, r, x[32:1], x[0]);
    end
  endtask

  task automatic chk(input logic g, input logic x);
    n_checks++;
    if (g !== x) begin
      miscompares++;
      $display("unexpected at %0t: output %b wanted %b", $time, g, x);
    end
  endtask

  // expected answer goes on the queue; the watcher below pops it on ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic ee);
    q.push_back({!w, d, ee});
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    addr <= a;
    wdat <= d;
    @(posedge ref_clk_i);
    pen <= 1'b1;
    // no wait count is assumed; only the watchdog ends a wait with no answer
    do begin
      @(posedge ref_clk_i);
    end while (rdy !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  always @(posedge ref_clk_i) begin
    if (rdy === 1'b1) begin
      e = q.pop_front();
      cmp_bus(rdat, serr, e);
    end
  end

  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic put(input logic [3:0] v);
    want <= v;
    tk(20);
  endtask

  task automatic pulse();
    req <= 1'b1;
    tk(6);
    req <= 1'b0;
    tk(6);
  endtask

  function automatic logic pexp(input logic [2:0] m, input logic [3:0] s);
    case (m)
      3'h0: return s[0];
      3'h1: return s[0] & s[1];
      3'h2: return s[0] & !s[1];
      3'h3: return &s;
      default: return s[0] & !s[1] & s[2] & !s[3];
    endcase
  endfunction

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    rst_i = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    addr = 12'h000;
    wdat = 32'h0;
    req = 1'b0;
    en = 1'b1;
    want = 4'h0;
    miscompares = 0;
    n_checks = 0;
    void'($urandom(32'h56e50135));
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    apb(0, CTRL_OFS, 32'h1, 0);
    apb(0, DISC1_OFS, 32'h3, 0);
    apb(0, DISC2_OFS, 32'h3, 0);
    apb(0, SYNC_OFS, 32'h1e, 0);
    apb(0, 12'h014, 32'h0, 1);
    apb(1, STAT_OFS, 32'h0, 1);
    apb(1, CTRL_OFS, 32'h5, 1);
    apb(1, DISC1_OFS, 32'hbb9, 1);
    apb(1, DISC1_OFS, 32'hbb8, 0);
    apb(0, DISC1_OFS, 32'hbb8, 0);
    apb(1, DISC1_OFS, 32'h0, 0);
    apb(1, DISC2_OFS, 32'h0, 0);
    apb(1, SYNC_OFS, 32'h0, 0);
    for (int m = 0; m < 5; m++) begin
      apb(1, CTRL_OFS, ENS | m, 0);
      apb(1, CTRL_OFS, ENS | RUN | m, 0);
      for (int i = 0; i < 24; i++) begin
        put(4'($urandom));
        chk(permit, pexp(3'(m), want));
        chk(fault, 1'b0);
      end
    end
    apb(1, DISC1_OFS, 32'ha, 0);
    apb(1, CTRL_OFS, ENS | RUN | 32'h1, 0);
    put(4'h3);
    chk(permit, 1'b1);
    want <= 4'h1;
    tk(24);
    chk(d1, 1'b0);
    tk(60);
    chk(d1, 1'b1);
    chk(fault, 1'b1);
    chk(permit, 1'b0);
    put(4'h3);
    chk(permit, 1'b0);
    put(4'h0);
    put(4'h3);
    chk(d1, 1'b0);
    chk(permit, 1'b1);
    apb(1, CTRL_OFS, RUN | 32'h1, 0);
    want <= 4'h1;
    tk(84);
    chk(d1, 1'b0);
    chk(fault, 1'b0);
    put(4'h3);
    chk(permit, 1'b0);
    apb(1, CTRL_OFS, 32'h1, 0);
    apb(1, CTRL_OFS, RUN | 32'h1, 0);
    tk(8);
    chk(permit, 1'b1);
    apb(1, DISC1_OFS, 32'h0, 0);
    apb(1, DISC2_OFS, 32'h3, 0);
    apb(1, CTRL_OFS, ENS | RUN | 32'h3, 0);
    put(4'hf);
    chk(permit, 1'b1);
    want <= 4'hb;
    tk(40);
    chk(d2, 1'b1);
    chk(d1, 1'b0);
    put(4'hf);
    put(4'hc);
    put(4'hf);
    chk(d2, 1'b1);
    put(4'h0);
    put(4'hf);
    chk(d2, 1'b0);
    chk(permit, 1'b1);
    apb(1, DISC2_OFS, 32'h0, 0);
    apb(1, SYNC_OFS, 32'h2, 0);
    put(4'h0);
    want <= 4'h3;
    tk(40);
    chk(sy, 1'b1);
    chk(permit, 1'b0);
    put(4'hf);
    chk(permit, 1'b0);
    put(4'h0);
    put(4'hf);
    chk(sy, 1'b0);
    apb(1, CTRL_OFS, ENS | FTE | 32'h1, 0);
    put(4'h3);
    apb(1, CTRL_OFS, ENS | FTE | RUN | 32'h1, 0);
    tk(8);
    chk(tn, 1'b1);
    chk(permit, 1'b0);
    put(4'h0);
    chk(tn, 1'b1);
    put(4'h3);
    chk(tn, 1'b0);
    chk(permit, 1'b1);
    pulse();
    chk(tn, 1'b1);
    pulse();
    chk(te, 1'b1);
    chk(permit, 1'b0);
    put(4'h0);
    put(4'h3);
    chk(te, 1'b0);
    chk(permit, 1'b1);
    apb(0, STAT_OFS, 32'h181, 0);
    // a low clock enable must freeze the permit while the contacts move
    en <= 1'b0;
    want <= 4'h1;
    tk(20);
    chk(permit, 1'b1);
    en <= 1'b1;
    tk(20);
    chk(permit, 1'b0);
    put(4'h3);
    chk(permit, 1'b1);
    tk(4);
    tally_and_finish();
  end
endmodule // sgm_top_bench
`default_nettype wire
